// ---- ppio_top.sv ----
// Programmable 24-line parallel port with three byte ports and a write-only control word.
`timescale 1ns/1ps
`default_nettype none
module ppio_top (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [1:0] addr_i,
  input  wire logic       cs_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  input  wire logic [7:0] first_i,
  output logic      [7:0] first_o,
  output logic      [7:0] first_oe_o,
  input  wire logic [7:0] second_i,
  output logic      [7:0] second_o,
  output logic      [7:0] second_oe_o,
  input  wire logic [7:0] third_i,
  output logic      [7:0] third_o,
  output logic      [7:0] third_oe_o,
  output logic            first_irq_o,
  output logic            second_irq_o
);
  ppio_pkg::ppio_mode_t first_mode_r;
  ppio_pkg::ppio_mode_t second_mode_r;
  logic       first_in_r, second_in_r, thi_in_r, tlo_in_r;
  logic [7:0] first_out_r, second_out_r, third_out_r;
  logic [7:0] third_bit_nxt;
  logic       wr_first, wr_second, wr_third, wr_ctrl, rd_first, rd_second;
  logic [7:0] fa_latch, sb_latch;
  logic       fa_ibf, fa_obf_n, sb_ibf, sb_obf_n;
  logic       fa_hs, sb_hs, fa_bidir;

  assign wr_first  = cs_i && wr_i && addr_i == ppio_pkg::OFS_FIRST;
  assign wr_second = cs_i && wr_i && addr_i == ppio_pkg::OFS_SECOND;
  assign wr_third  = cs_i && wr_i && addr_i == ppio_pkg::OFS_THIRD;
  assign wr_ctrl   = cs_i && wr_i && addr_i == ppio_pkg::OFS_CTRL;
  assign rd_first  = cs_i && rd_i && addr_i == ppio_pkg::OFS_FIRST;
  assign rd_second = cs_i && rd_i && addr_i == ppio_pkg::OFS_SECOND;
  assign fa_hs    = first_mode_r != ppio_pkg::PPIO_BASIC;
  assign fa_bidir = first_mode_r == ppio_pkg::PPIO_BIDIR;
  assign sb_hs    = second_mode_r != ppio_pkg::PPIO_BASIC;

  // mode definition on bit 7 high
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      first_mode_r  <= ppio_pkg::PPIO_BASIC;
      second_mode_r <= ppio_pkg::PPIO_BASIC;
      first_in_r    <= 1'b1;
      second_in_r   <= 1'b1;
      thi_in_r      <= 1'b1;
      tlo_in_r      <= 1'b1;
    end else if (wr_ctrl && wdata_i[ppio_pkg::CW_DEFINE]) begin
      // mode fields; bit 6 set selects bidirectional
      if (wdata_i[ppio_pkg::CW_FIRST_MHI])
        first_mode_r <= ppio_pkg::PPIO_BIDIR;
      else if (wdata_i[ppio_pkg::CW_FIRST_MLO])
        first_mode_r <= ppio_pkg::PPIO_STROBED;
      else
        first_mode_r <= ppio_pkg::PPIO_BASIC;
      second_mode_r <= wdata_i[ppio_pkg::CW_SECOND_MD] ? ppio_pkg::PPIO_STROBED
                                                       : ppio_pkg::PPIO_BASIC;
      first_in_r  <= wdata_i[ppio_pkg::CW_FIRST_DIR];
      second_in_r <= wdata_i[ppio_pkg::CW_SECOND_DIR];
      thi_in_r    <= wdata_i[ppio_pkg::CW_THIRD_HDIR];
      tlo_in_r    <= wdata_i[ppio_pkg::CW_THIRD_LDIR];
    end
  end

  // output latches hold until rewritten; a mode write clears them
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      first_out_r  <= ppio_pkg::OUT_RESET;
      second_out_r <= ppio_pkg::OUT_RESET;
    end else if (wr_ctrl && wdata_i[ppio_pkg::CW_DEFINE]) begin
      first_out_r  <= ppio_pkg::OUT_RESET;
      second_out_r <= ppio_pkg::OUT_RESET;
    end else begin
      if (wr_first)
        first_out_r <= wdata_i;
      if (wr_second)
        second_out_r <= wdata_i;
    end
  end

  ppio_bitop u_bitop (
    .cw_i  (wdata_i),
    .cur_i (third_out_r),
    .nxt_o (third_bit_nxt)
  );

  // single-bit operation; works on handshake bits too
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      third_out_r <= ppio_pkg::OUT_RESET;
    else if (wr_ctrl && wdata_i[ppio_pkg::CW_DEFINE])
      third_out_r <= ppio_pkg::OUT_RESET;
    else if (wr_ctrl)
      third_out_r <= third_bit_nxt;
    else if (wr_third)
      third_out_r <= wdata_i;
  end

  // first group, handshakes on the upper third-port lines
  ppio_strobe_grp #(.W(8)) u_grp_first (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .stb_n_i      (fa_hs ? third_i[ppio_pkg::FA_STBN] : 1'b1),
    .ack_n_i      (fa_hs ? third_i[ppio_pkg::FA_ACKN] : 1'b1),
    .pins_i       (first_i),
    .rd_data_i    (rd_first && fa_hs),
    .wr_data_i    (wr_first && fa_hs),
    .in_latch_o   (fa_latch),
    .in_full_o    (fa_ibf),
    .out_full_n_o (fa_obf_n)
  );

  // second group, handshakes on the lower third-port lines
  ppio_strobe_grp #(.W(8)) u_grp_second (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .stb_n_i      (sb_hs && second_in_r ? third_i[ppio_pkg::SB_STRB] : 1'b1),
    .ack_n_i      (sb_hs && !second_in_r ? third_i[ppio_pkg::SB_STRB] : 1'b1),
    .pins_i       (second_i),
    .rd_data_i    (rd_second && sb_hs),
    .wr_data_i    (wr_second && sb_hs),
    .in_latch_o   (sb_latch),
    .in_full_o    (sb_ibf),
    .out_full_n_o (sb_obf_n)
  );

  // interrupt requests gated by enable bits held in the third-port latch
  // these requests also drive third-port lines FA_INTR and SB_INTR, which a third-port read returns
  assign first_irq_o = fa_hs &&
    (((fa_bidir || first_in_r) && fa_ibf && third_out_r[ppio_pkg::FA_IE_IN]) ||
     ((fa_bidir || !first_in_r) && fa_obf_n && third_out_r[ppio_pkg::FA_IE_OUT]));
  assign second_irq_o = sb_hs && third_out_r[ppio_pkg::SB_IE] &&
    (second_in_r ? sb_ibf : sb_obf_n);

  // pin drive; four independent direction units
  always_comb begin
    first_o     = first_out_r;
    first_oe_o  = first_in_r ? 8'h00 : 8'hff;
    second_o    = second_out_r;
    second_oe_o = second_in_r ? 8'h00 : 8'hff;
    third_o     = third_out_r;
    third_oe_o  = {{4{!thi_in_r}}, {4{!tlo_in_r}}};
    // bus driven only while the peripheral acknowledges
    if (fa_bidir)
      first_oe_o = third_i[ppio_pkg::FA_ACKN] ? 8'h00 : 8'hff;
    // device drives its status lines, peripheral owns the strobes
    if (fa_hs) begin
      third_o[ppio_pkg::FA_INTR]    = first_irq_o;
      third_oe_o[ppio_pkg::FA_INTR] = 1'b1;
      third_oe_o[ppio_pkg::FA_STBN] = !(fa_bidir || first_in_r);
      third_oe_o[ppio_pkg::FA_ACKN] = !(fa_bidir || !first_in_r);
      if (fa_bidir || first_in_r) begin
        third_o[ppio_pkg::FA_IBF]    = fa_ibf;
        third_oe_o[ppio_pkg::FA_IBF] = 1'b1;
      end
      if (fa_bidir || !first_in_r) begin
        third_o[ppio_pkg::FA_OBFN]    = fa_obf_n;
        third_oe_o[ppio_pkg::FA_OBFN] = 1'b1;
      end
    end
    if (sb_hs) begin
      third_o[ppio_pkg::SB_INTR]    = second_irq_o;
      third_o[ppio_pkg::SB_OBFN]    = second_in_r ? sb_ibf : sb_obf_n;
      third_oe_o[ppio_pkg::SB_INTR] = 1'b1;
      third_oe_o[ppio_pkg::SB_OBFN] = 1'b1;
      third_oe_o[ppio_pkg::SB_STRB] = 1'b0;
    end
  end

  // basic input reads see live pins, basic output reads the output latch; strobed input reads see the input latch
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (cs_i && rd_i) begin
      unique case (addr_i)
        ppio_pkg::OFS_FIRST:
          rdata_o <= (fa_hs && (fa_bidir || first_in_r)) ? fa_latch
                   : (first_in_r ? first_i : first_out_r);
        ppio_pkg::OFS_SECOND:
          rdata_o <= (sb_hs && second_in_r) ? sb_latch
                   : (second_in_r ? second_i : second_out_r);
        ppio_pkg::OFS_THIRD:
          rdata_o <= (third_i & ~third_oe_o) | (third_o & third_oe_o);
        // The control word is write only.
        ppio_pkg::OFS_CTRL:
          rdata_o <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- ppio_pkg.sv ----
// Package with register offsets, control word fields and modes for the parallel port block.
package ppio_pkg;
  localparam logic [1:0] OFS_FIRST  = 2'h0;
  localparam logic [1:0] OFS_SECOND = 2'h1;
  localparam logic [1:0] OFS_THIRD  = 2'h2;
  localparam logic [1:0] OFS_CTRL   = 2'h3;
  localparam int CW_DEFINE     = 7;
  localparam int CW_FIRST_MHI  = 6;
  localparam int CW_FIRST_MLO  = 5;
  localparam int CW_FIRST_DIR  = 4;
  localparam int CW_THIRD_HDIR = 2;
  localparam int CW_SECOND_MD  = 3;
  localparam int CW_SECOND_DIR = 1;
  localparam int CW_THIRD_LDIR = 0;
  localparam int BSR_SEL_HI    = 3;
  localparam int BSR_SEL_LO    = 1;
  localparam int BSR_VAL       = 0;
  localparam logic [7:0] OUT_RESET = 8'h00;
  // Third-port bit positions used for handshakes.
  localparam int FA_INTR = 3;
  localparam int FA_STBN = 4;
  localparam int FA_IBF  = 5;
  localparam int FA_ACKN = 6;
  localparam int FA_OBFN = 7;
  localparam int SB_INTR = 0;
  localparam int SB_OBFN = 1;
  localparam int SB_STRB = 2;
  localparam int FA_IE_IN  = 4;
  localparam int FA_IE_OUT = 6;
  localparam int SB_IE     = 2;
  typedef enum logic [1:0] {PPIO_BASIC, PPIO_STROBED, PPIO_BIDIR} ppio_mode_t;
endpackage

// ---- ppio_strobe_grp.sv ----
// One strobed group: input latch on strobe, output full flag cleared on acknowledge.
`timescale 1ns/1ps
`default_nettype none
module ppio_strobe_grp #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         stb_n_i,
  input  wire logic         ack_n_i,
  input  wire logic [W-1:0] pins_i,
  input  wire logic         rd_data_i,
  input  wire logic         wr_data_i,
  output logic [W-1:0]      in_latch_o,
  output logic              in_full_o,
  output logic              out_full_n_o
);
  logic stb_q_r;
  logic ack_q_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stb_q_r <= 1'b1;
      ack_q_r <= 1'b1;
    end else begin
      stb_q_r <= stb_n_i;
      ack_q_r <= ack_n_i;
    end
  end
  // Input side: latch on strobe fall; a strobe wins over a concurrent read.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_latch_o <= '0;
      in_full_o  <= 1'b0;
    end else if (!stb_n_i && stb_q_r) begin
      in_latch_o <= pins_i;
      in_full_o  <= 1'b1;
    end else if (rd_data_i) begin
      in_full_o  <= 1'b0;
    end
  end
  // Output side: a write marks the buffer full; an acknowledge empties it.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_full_n_o <= 1'b1;
    end else if (wr_data_i) begin
      out_full_n_o <= 1'b0;
    end else if (!ack_n_i && ack_q_r) begin
      out_full_n_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- ppio_bitop.sv ----
// Decoder for the single-bit set or clear of the third port.
`timescale 1ns/1ps
`default_nettype none
module ppio_bitop (
  input  wire logic [7:0] cw_i,
  input  wire logic [7:0] cur_i,
  output logic [7:0]      nxt_o
);
  logic [2:0] sel;
  assign sel = cw_i[ppio_pkg::BSR_SEL_HI:ppio_pkg::BSR_SEL_LO];
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      assign nxt_o[g] = (sel == 3'(g)) ? cw_i[ppio_pkg::BSR_VAL] : cur_i[g];
    end
  endgenerate
endmodule
`default_nettype wire

// ---- ppio_checker.sv ----
// Port-level checker for the parallel port block.
`timescale 1ns/1ps
`default_nettype none
module ppio_checker (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic [1:0] addr_i,
  input wire logic       cs_i,
  input wire logic       rd_i,
  input wire logic       wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] first_o,
  input wire logic [7:0] first_oe_o,
  input wire logic [7:0] second_i,
  input wire logic [7:0] second_o,
  input wire logic [7:0] second_oe_o,
  input wire logic [7:0] third_o,
  input wire logic [7:0] third_oe_o
);
  logic basic_r;
  wire  cw_wr = cs_i && wr_i && addr_i == 2'h3;
  // The mode word cannot be read back, so basic mode is tracked here.
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      basic_r <= 1'b1;
    else if (cw_wr && wdata_i[7])
      basic_r <= wdata_i[6:5] == 2'h0 && !wdata_i[ppio_pkg::CW_SECOND_MD];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_def;
    cw_wr && wdata_i[7] && wdata_i[6:5] == 2'h0 && !wdata_i[ppio_pkg::CW_SECOND_MD];
  endsequence
  sequence s_bit;
    cw_wr && !wdata_i[7] && basic_r && third_oe_o[wdata_i[3:1]];
  endsequence
  ctrl_rd_zero_a:
    assert property (cs_i && rd_i && addr_i == 2'h3 |=> rdata_o == 8'h00) else $error("ctrl rd");
  byte_dirs_a:
    assert property (s_def |=> first_oe_o == {8{!$past(wdata_i[4])}}
      && second_oe_o == {8{!$past(wdata_i[1])}}) else $error("byte dir");
  nib_dirs_a:
    assert property (s_def |=> third_oe_o ==
      {{4{!$past(wdata_i[ppio_pkg::CW_THIRD_HDIR])}}, {4{!$past(wdata_i[0])}}})
      else $error("nibble dir");
  def_clear_a:
    assert property (s_def |=> (first_o | second_o | third_o) == 8'h00) else $error("clear");
  bit_op_a:
    assert property (s_bit |=> third_o[$past(wdata_i[3:1])] == $past(wdata_i[0])) else $error("bit");
  latch_hold_a:
    assert property (basic_r && !cw_wr && !(cs_i && wr_i && addr_i == 2'h0) |=> $stable(first_o))
      else $error("hold");
  live_read_a:
    assert property (basic_r && cs_i && rd_i && addr_i == 2'h1 && second_oe_o == 8'h00
      |=> rdata_o == $past(second_i)) else $error("live read");
  reset_dirs_a:
    assert property ($rose(resetn_i) |-> (first_oe_o | second_oe_o | third_oe_o) == 8'h00)
      else $error("reset dir");
endmodule
`default_nettype wire

// ---- ppio_periph_model.sv ----
// Peripheral model on the pin side of the three byte ports.
`timescale 1ns/1ps
`default_nettype none
module ppio_periph_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] dev1_i,
  input  wire logic [7:0] oe1_i,
  input  wire logic [7:0] dev2_i,
  input  wire logic [7:0] oe2_i,
  input  wire logic [7:0] dev3_i,
  input  wire logic [7:0] oe3_i,
  output logic      [7:0] pin1_o,
  output logic      [7:0] pin2_o,
  output logic      [7:0] pin3_o
);
  logic [7:0] drv1 = 8'h00;
  logic [7:0] drv2 = 8'h00;
  logic [7:0] drv3 = 8'hff;
  // The model drives every line that the device leaves as an input.
  assign pin1_o = (dev1_i & oe1_i) | (drv1 & ~oe1_i);
  assign pin2_o = (dev2_i & oe2_i) | (drv2 & ~oe2_i);
  assign pin3_o = (dev3_i & oe3_i) | (drv3 & ~oe3_i);
  task automatic put(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge clk_i);
    drv1 <= a;
    drv2 <= b;
    drv3 <= c;
  endtask
  task automatic strobe_first(input logic [7:0] d);
    put(d, drv2, drv3);
    @(posedge clk_i);
    drv3[ppio_pkg::FA_STBN] <= 1'b0;
    repeat (2) @(posedge clk_i);
    drv3[ppio_pkg::FA_STBN] <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the parallel port block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk_i, resetn_i, cs_i, rd_i, wr_i, pk, pend, first_irq_o, second_irq_o;
  logic [1:0] addr_i;
  logic [2:0] what;
  logic [7:0] wdata_i, rdata_o, first_i, first_o, first_oe_o, second_i, second_o;
  logic [7:0] second_oe_o, third_i, third_o, third_oe_o, v, e3;
  logic [7:0] q[$];
  int         error_cnt, compares, seed, i;
  ppio_top u_dut (.clk_i, .resetn_i, .addr_i, .cs_i, .rd_i, .wr_i, .wdata_i, .rdata_o,
    .first_i, .first_o, .first_oe_o, .second_i, .second_o, .second_oe_o, .third_i,
    .third_o, .third_oe_o, .first_irq_o, .second_irq_o);
  ppio_periph_model u_per (.clk_i, .dev1_i(first_o), .oe1_i(first_oe_o),
    .dev2_i(second_o), .oe2_i(second_oe_o), .dev3_i(third_o), .oe3_i(third_oe_o),
    .pin1_o(first_i), .pin2_o(second_i), .pin3_o(third_i));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic cmp_rdata(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD rdata exp %h got %h", e, g);
    end
  endtask
  task automatic cmp_pin(input logic [2:0] w, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD pin%0d exp %h got %h", w, e, g);
    end
  endtask
  function automatic logic [7:0] pick(input logic [2:0] w);
    logic [7:0] a [7];
    a = '{first_o, second_o, third_o, first_oe_o, second_oe_o, third_oe_o,
      {6'h0, second_irq_o, first_irq_o}};
    return a[w];
  endfunction
  // Read data is registered, so it is judged one edge after the taking edge.
  always @(posedge clk_i) begin
    if (pend) cmp_rdata(q.pop_front(), rdata_o);
    if (pk) cmp_pin(what, q.pop_front(), pick(what));
    pend = cs_i && rd_i;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cs_i <= 1'b1;
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    cs_i <= 1'b0;
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_i);
    q.push_back(e);
    cs_i <= 1'b1;
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    cs_i <= 1'b0;
    rd_i <= 1'b0;
  endtask
  task automatic peek(input logic [2:0] w, input logic [7:0] e);
    @(posedge clk_i);
    q.push_back(e);
    pk <= 1'b1;
    what <= w;
    @(posedge clk_i);
    pk <= 1'b0;
  endtask
  task automatic conclude();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    seed = 32'hc8deede6;
    {cs_i, rd_i, wr_i, pk, pend, resetn_i} = 6'h00;
    addr_i = 2'h0;
    wdata_i = 8'h00;
    what = 3'h0;
    error_cnt = 0;
    compares = 0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (i = 0; i < 7; i++) peek(i[2:0], 8'h00);
    v = 8'($random(seed));
    u_per.put(v, ~v, v ^ 8'h5a);
    rd(2'h0, v);
    rd(2'h1, ~v);
    rd(2'h2, v ^ 8'h5a);
    rd(2'h3, 8'h00);
    for (i = 0; i < 16; i++) begin
      wr(2'h3, {3'h4, i[3], 1'b0, i[2:0]});
      peek(3'h3, {8{~i[3]}});
      peek(3'h4, {8{~i[1]}});
      peek(3'h5, {{4{~i[2]}}, {4{~i[0]}}});
      v = 8'($random(seed));
      u_per.put(v, ~v, 8'hff);
      if (i[3]) rd(2'h0, v);
      if (i[1]) rd(2'h1, ~v);
    end
    wr(2'h3, 8'h80);
    for (i = 0; i < 3; i++) begin
      v = 8'($random(seed));
      wr(i[1:0], v);
      u_per.put(~v, ~v, ~v);
      peek(i[2:0], v);
    end
    e3 = v;
    for (i = 15; i >= 0; i--) begin
      wr(2'h3, {4'h0, i[3:0]});
      e3[i[3:1]] = i[0];
      peek(3'h2, e3);
    end
    u_per.put(8'h00, 8'h00, 8'hff);
    wr(2'h3, 8'hb0);
    wr(2'h3, {4'h0, 3'(ppio_pkg::FA_IE_IN), 1'b1});
    v = 8'($random(seed));
    u_per.strobe_first(v);
    for (i = 0; i < 20 && third_o[ppio_pkg::FA_IBF] !== 1'b1; i++) @(posedge clk_i);
    // A strobe that never latches counts as a mismatch; the run still ends below.
    if (i == 20) error_cnt++;
    peek(3'h6, 8'h01);
    u_per.put(~v, 8'h00, 8'hff);
    rd(2'h0, v);
    // Bidirectional first group: the bus is driven only while ack is low.
    wr(2'h3, 8'hc0);
    wr(2'h0, v);
    peek(3'h2, 8'h00);
    u_per.put(v, 8'h00, 8'hbf);
    peek(3'h3, 8'hff);
    peek(3'h2, 8'h80);
    u_per.put(v, 8'h00, 8'hff);
    peek(3'h3, 8'h00);
    // Second group strobed output, its mode picked by control bit 3.
    wr(2'h3, 8'h88);
    wr(2'h1, ~v);
    peek(3'h2, 8'h00);
    u_per.put(v, 8'h00, 8'hfb);
    peek(3'h2, 8'h02);
    repeat (2) @(posedge clk_i);
    conclude();
  end
endmodule
bind ppio_top ppio_checker u_chk (.clk_i, .resetn_i, .addr_i, .cs_i, .rd_i, .wr_i,
  .wdata_i, .rdata_o, .first_o, .first_oe_o, .second_i, .second_o, .second_oe_o,
  .third_o, .third_oe_o);
`default_nettype wire
